// >>> pps_pkg.sv
// shared constants of the pwm and port-mode register bank
package pps_pkg;
    // bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int DUTY_W = 10;
    localparam int CKS_W  = 2;
    localparam int MODE_W = 2;

    // register offsets as byte addresses on the register port
    localparam logic [7:0] ADR_FIRST_PERIOD      = 8'h9a;
    localparam logic [7:0] ADR_FIRST_DUTY_HIGH   = 8'h9b;
    localparam logic [7:0] ADR_SECOND_PERIOD     = 8'h9c;
    localparam logic [7:0] ADR_SECOND_DUTY_HIGH  = 8'h9d;
    localparam logic [7:0] ADR_THIRD_PERIOD      = 8'h9e;
    localparam logic [7:0] ADR_THIRD_DUTY_HIGH   = 8'h9f;
    localparam logic [7:0] ADR_PORT_TWO_DATA     = 8'ha0;
    localparam logic [7:0] ADR_CLOCK_DUTY_CTRL   = 8'ha1;
    localparam logic [7:0] ADR_PORT_ONE_MODE_LOW = 8'ha2;
    localparam logic [7:0] ADR_PORT_ONE_MODE_HI  = 8'ha3;
    localparam logic [7:0] ADR_PORT_THREE_MODE_L = 8'ha4;
    localparam logic [7:0] ADR_CONTROL_SECOND    = 8'ha7;

    // reset values
    localparam logic [7:0] RST_PERIOD     = 8'hff;
    localparam logic [7:0] RST_DUTY_HIGH  = 8'h80;
    localparam logic [5:0] RST_P2_SCRATCH = 6'h3f;
    localparam logic [1:0] RST_P2_PINS    = 2'h3;
    localparam logic [1:0] RST_DUTY_LOW   = 2'h0;
    localparam logic [1:0] RST_CKS        = 2'h2;
    localparam logic [1:0] RST_MODE       = 2'h1;
    localparam logic [7:0] RST_MODE_REG   = 8'h55;

    // field positions (low bit of each field)
    localparam int POS_SECOND_CKS   = 6;
    localparam int POS_SECOND_DL    = 4;
    localparam int POS_FIRST_CKS    = 2;
    localparam int POS_FIRST_DL     = 0;
    localparam int POS_THIRD_CKS    = 2;
    localparam int POS_THIRD_DL     = 0;
    localparam int POS_P3_PIN3_MODE = 6;
    localparam int POS_P2_SCRATCH   = 2;

    // clock select codes
    localparam logic [1:0] CKS_DIV4 = 2'h0;
    localparam logic [1:0] CKS_DIV2 = 2'h1;
    localparam logic [1:0] CKS_SYS  = 2'h2;
    localparam logic [1:0] CKS_FRC  = 2'h3;

    // pin mode codes
    localparam logic [1:0] MODE_0 = 2'h0;
    localparam logic [1:0] MODE_1 = 2'h1;
    localparam logic [1:0] MODE_2 = 2'h2;
    localparam logic [1:0] MODE_3 = 2'h3;

    // pins of port one that reach the converter in mode 3
    localparam int ADC_PINS = 6;

    // divider terminal count for the quarter rate
    localparam logic [1:0] DIV_LAST = 2'h3;
endpackage : pps_pkg

// >>> pps_sfr_bank.sv
// Overview of operation
// - second and third period bytes, read/write, reset to ff
// - second channel duty bits 9..2 in own byte, reset 80
// - third channel duty bits 9..2 in own byte, reset 80
// - second channel duty bits 1..0 in control bits 5..4, reset 0
// - first channel duty bits 1..0 in control bits 1..0, reset 0
// - clock select 00 /4, 01 /2, 10 full, 11 fast rc; reset 10
// - port two bits 7..2 scratch reset 3f, bits 1..0 pin data reset 11
// - each port one pin and port three pin 3 has two-bit mode field, codes map to modes 0..3, reset 01
// - mode 3 on port one pins 0..5 routes pin to converter
// - port one mode low holds pins 3..0, high holds pins 7..4
// - port three pin 3 mode in bits 7..6 of its low register
// - first channel period resets ff, duty high byte resets 80
// - third channel low duty and clock select in second control register
`timescale 1ns/1ns
module pps_sfr_bank (
    input  wire logic                        sys_clk_i,        // system clock, 50 mhz
    input  wire logic                        resetn_i,         // async reset, active low
    input  wire logic [pps_pkg::ADDR_W-1:0]  reg_addr_i,       // register address
    input  wire logic [pps_pkg::DATA_W-1:0]  reg_wdata_i,      // write data
    input  wire logic                        reg_wr_i,         // write strobe
    input  wire logic                        reg_rd_i,         // read strobe
    output logic      [pps_pkg::DATA_W-1:0]  reg_rdata_o,      // read data, cycle after strobe
    input  wire logic                        fast_rc_clock_i,  // fast rc tick, sync enable
    output logic      [pps_pkg::DATA_W-1:0]  first_period_o,   // first channel period
    output logic      [pps_pkg::DATA_W-1:0]  second_period_o,  // second channel period
    output logic      [pps_pkg::DATA_W-1:0]  third_period_o,   // third channel period
    output logic      [pps_pkg::DUTY_W-1:0]  first_duty_o,     // first channel 10-bit duty
    output logic      [pps_pkg::DUTY_W-1:0]  second_duty_o,    // second channel 10-bit duty
    output logic      [pps_pkg::DUTY_W-1:0]  third_duty_o,     // third channel 10-bit duty
    output logic      [pps_pkg::CKS_W-1:0]   first_cks_o,      // first channel clock select
    output logic      [pps_pkg::CKS_W-1:0]   second_cks_o,     // second channel clock select
    output logic      [pps_pkg::CKS_W-1:0]   third_cks_o,      // third channel clock select
    output logic                             first_tick_o,     // first channel count enable
    output logic                             second_tick_o,    // second channel count enable
    output logic                             third_tick_o,     // third channel count enable
    output logic      [1:0]                  port_two_pins_o,  // port two pin data
    output logic      [15:0]                 port_one_mode_o,  // port one modes, pin n at 2n
    output logic      [pps_pkg::ADC_PINS-1:0] port_one_adc_o,  // port one converter connects
    output logic      [pps_pkg::MODE_W-1:0]  port_three_pin3_mode_o  // port three pin 3 mode
);
    import pps_pkg::*;

    // reset release synchroniser
    logic rst_meta_r;
    logic rst_n_sync;
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_r <= 1'b0;
            rst_n_sync <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_sync <= rst_meta_r;
        end
    end

    // register storage
    logic [7:0] first_channel_period_r;
    logic [7:0] first_channel_duty_high_r;
    logic [7:0] second_channel_period_r;
    logic [7:0] second_channel_duty_high_r;
    logic [7:0] third_channel_period_r;
    logic [7:0] third_channel_duty_high_r;
    logic [7:0] port_two_data_r;
    logic [7:0] pulse_clock_duty_control_r;
    logic [3:0] pulse_control_second_r;
    logic [7:0] port_one_mode_low_r;
    logic [7:0] port_one_mode_high_r;
    logic [1:0] port_three_pin3_mode_r;
    logic [7:0] rdata_nxt;
    logic [7:0] rdata_r;
    logic [1:0] div_cnt_r;
    logic       first_tick_r;
    logic       second_tick_r;
    logic       third_tick_r;

    // write hit on a given offset
    function automatic logic wr_hit(input logic [7:0] adr, input logic [7:0] off, input logic wr);
        wr_hit = wr && (adr == off);
    endfunction

    // enable pulse chosen by a clock select code
    function automatic logic pick_tick(input logic [1:0] cks, input logic [1:0] cnt, input logic fast_rc_clock);
        case (cks)
            CKS_DIV4: pick_tick = (cnt == DIV_LAST);
            CKS_DIV2: pick_tick = cnt[0];
            CKS_SYS:  pick_tick = 1'b1;
            CKS_FRC:  pick_tick = fast_rc_clock;
            default:  pick_tick = 1'b0;
        endcase
    endfunction

    // mode 3 selects the converter input
    function automatic logic is_adc(input logic [1:0] mode);
        is_adc = (mode == MODE_3);
    endfunction

    // first channel period and duty high byte
    // first channel reset
    always_ff @(posedge sys_clk_i or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            first_channel_period_r    <= RST_PERIOD;
            first_channel_duty_high_r <= RST_DUTY_HIGH;
        end else begin
            if (wr_hit(reg_addr_i, ADR_FIRST_PERIOD, reg_wr_i)) begin
                first_channel_period_r <= reg_wdata_i;
            end
            if (wr_hit(reg_addr_i, ADR_FIRST_DUTY_HIGH, reg_wr_i)) begin
                first_channel_duty_high_r <= reg_wdata_i;
            end
        end
    end

    // second channel period and duty high byte
    // second period byte
    always_ff @(posedge sys_clk_i or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            second_channel_period_r    <= RST_PERIOD;
            second_channel_duty_high_r <= RST_DUTY_HIGH;
        end else begin
            if (wr_hit(reg_addr_i, ADR_SECOND_PERIOD, reg_wr_i)) begin
                second_channel_period_r <= reg_wdata_i;
            end
            if (wr_hit(reg_addr_i, ADR_SECOND_DUTY_HIGH, reg_wr_i)) begin
                second_channel_duty_high_r <= reg_wdata_i;
            end
        end
    end

    // third channel period and duty high byte
    // third period byte
    always_ff @(posedge sys_clk_i or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            third_channel_period_r    <= RST_PERIOD;
            third_channel_duty_high_r <= RST_DUTY_HIGH;
        end else begin
            if (wr_hit(reg_addr_i, ADR_THIRD_PERIOD, reg_wr_i)) begin
                third_channel_period_r <= reg_wdata_i;
            end
            if (wr_hit(reg_addr_i, ADR_THIRD_DUTY_HIGH, reg_wr_i)) begin
                third_channel_duty_high_r <= reg_wdata_i;
            end
        end
    end

    // port two data, scratch bits and pin bits
    // port two reset
    always_ff @(posedge sys_clk_i or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            port_two_data_r <= {RST_P2_SCRATCH, RST_P2_PINS};
        end else if (wr_hit(reg_addr_i, ADR_PORT_TWO_DATA, reg_wr_i)) begin
            port_two_data_r <= reg_wdata_i;
        end
    end

    // shared clock select and low duty control
    // second low duty
    always_ff @(posedge sys_clk_i or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            pulse_clock_duty_control_r <= {RST_CKS, RST_DUTY_LOW, RST_CKS, RST_DUTY_LOW};
        end else if (wr_hit(reg_addr_i, ADR_CLOCK_DUTY_CTRL, reg_wr_i)) begin
            pulse_clock_duty_control_r <= reg_wdata_i;
        end
    end

    // third channel clock select and low duty
    // second control register
    always_ff @(posedge sys_clk_i or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            pulse_control_second_r <= {RST_CKS, RST_DUTY_LOW};
        end else if (wr_hit(reg_addr_i, ADR_CONTROL_SECOND, reg_wr_i)) begin
            pulse_control_second_r <= reg_wdata_i[3:0];
        end
    end

    // port one and port three pin modes
    // mode fields reset
    always_ff @(posedge sys_clk_i or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            port_one_mode_low_r    <= RST_MODE_REG;
            port_one_mode_high_r   <= RST_MODE_REG;
            port_three_pin3_mode_r <= RST_MODE;
        end else begin
            if (wr_hit(reg_addr_i, ADR_PORT_ONE_MODE_LOW, reg_wr_i)) begin
                port_one_mode_low_r <= reg_wdata_i;
            end
            if (wr_hit(reg_addr_i, ADR_PORT_ONE_MODE_HI, reg_wr_i)) begin
                port_one_mode_high_r <= reg_wdata_i;
            end
            if (wr_hit(reg_addr_i, ADR_PORT_THREE_MODE_L, reg_wr_i)) begin
                port_three_pin3_mode_r <= reg_wdata_i[POS_P3_PIN3_MODE +: MODE_W];
            end
        end
    end

    // read mux, reserved and unmapped bits read zero
    // exact read back
    always_comb begin
        rdata_nxt = 8'h00;
        case (reg_addr_i)
            ADR_FIRST_PERIOD:      rdata_nxt = first_channel_period_r;
            ADR_FIRST_DUTY_HIGH:   rdata_nxt = first_channel_duty_high_r;
            ADR_SECOND_PERIOD:     rdata_nxt = second_channel_period_r;
            ADR_SECOND_DUTY_HIGH:  rdata_nxt = second_channel_duty_high_r;
            ADR_THIRD_PERIOD:      rdata_nxt = third_channel_period_r;
            ADR_THIRD_DUTY_HIGH:   rdata_nxt = third_channel_duty_high_r;
            ADR_PORT_TWO_DATA:     rdata_nxt = port_two_data_r;
            ADR_CLOCK_DUTY_CTRL:   rdata_nxt = pulse_clock_duty_control_r;
            ADR_PORT_ONE_MODE_LOW: rdata_nxt = port_one_mode_low_r;
            ADR_PORT_ONE_MODE_HI:  rdata_nxt = port_one_mode_high_r;
            ADR_PORT_THREE_MODE_L: rdata_nxt = {port_three_pin3_mode_r, 6'h00};
            ADR_CONTROL_SECOND:    rdata_nxt = {4'h0, pulse_control_second_r};
            default:               rdata_nxt = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk_i or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= reg_rd_i ? rdata_nxt : 8'h00;
        end
    end
    assign reg_rdata_o = rdata_r;

    // free-running divider for the half and quarter rates
    always_ff @(posedge sys_clk_i or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            div_cnt_r <= 2'h0;
        end else begin
            div_cnt_r <= div_cnt_r + 2'h1;
        end
    end

    // per-channel count enables from the clock selects
    // clock source choice
    always_ff @(posedge sys_clk_i or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            first_tick_r  <= 1'b0;
            second_tick_r <= 1'b0;
            third_tick_r  <= 1'b0;
        end else begin
            first_tick_r  <= pick_tick(first_cks_o, div_cnt_r, fast_rc_clock_i);
            second_tick_r <= pick_tick(second_cks_o, div_cnt_r, fast_rc_clock_i);
            third_tick_r  <= pick_tick(third_cks_o, div_cnt_r, fast_rc_clock_i);
        end
    end
    assign first_tick_o  = first_tick_r;
    assign second_tick_o = second_tick_r;
    assign third_tick_o  = third_tick_r;

    // channel values towards the waveform logic
    // duty concatenation
    assign first_period_o  = first_channel_period_r;
    assign second_period_o = second_channel_period_r;
    assign third_period_o  = third_channel_period_r;
    assign first_duty_o    = {first_channel_duty_high_r,
                              pulse_clock_duty_control_r[POS_FIRST_DL +: 2]};
    assign second_duty_o   = {second_channel_duty_high_r,
                              pulse_clock_duty_control_r[POS_SECOND_DL +: 2]};
    assign third_duty_o    = {third_channel_duty_high_r,
                              pulse_control_second_r[POS_THIRD_DL +: 2]};
    assign first_cks_o     = pulse_clock_duty_control_r[POS_FIRST_CKS +: CKS_W];
    assign second_cks_o    = pulse_clock_duty_control_r[POS_SECOND_CKS +: CKS_W];
    assign third_cks_o     = pulse_control_second_r[POS_THIRD_CKS +: CKS_W];

    // pin data and modes
    // port one field layout
    assign port_two_pins_o        = port_two_data_r[1:0];
    assign port_one_mode_o        = {port_one_mode_high_r, port_one_mode_low_r};
    assign port_three_pin3_mode_o = port_three_pin3_mode_r;

    // converter connects for port one pins 0..5 only
    // converter routing
    always_comb begin
        for (int i = 0; i < ADC_PINS; i++) begin
            port_one_adc_o[i] = is_adc(port_one_mode_o[2*i +: MODE_W]);
        end
    end

    // checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_sync);

    sequence s_wr(logic [7:0] off);
        reg_wr_i && reg_addr_i == off;
    endsequence

    sequence s_rd(logic [7:0] off);
        reg_rd_i && reg_addr_i == off;
    endsequence

    AST_SECOND_PERIOD_WR: assert property (
        s_wr(ADR_SECOND_PERIOD) |=> second_period_o == $past(reg_wdata_i))
        else $error("second period not updated by write");
    AST_SECOND_DUTY_HIGH: assert property (
        s_wr(ADR_SECOND_DUTY_HIGH) |=> second_duty_o[9:2] == $past(reg_wdata_i))
        else $error("second duty high byte wrong");
    AST_THIRD_DUTY_HIGH: assert property (
        s_wr(ADR_THIRD_DUTY_HIGH) |=> third_duty_o[9:2] == $past(reg_wdata_i))
        else $error("third duty high byte wrong");
    AST_SECOND_DUTY_LOW: assert property (
        s_wr(ADR_CLOCK_DUTY_CTRL) |=> second_duty_o[1:0] == $past(reg_wdata_i[5:4])
                                       && second_cks_o == $past(reg_wdata_i[7:6]))
        else $error("second low duty or select from wrong bits");
    AST_FIRST_DUTY_LOW: assert property (
        s_wr(ADR_CLOCK_DUTY_CTRL) |=> first_duty_o[1:0] == $past(reg_wdata_i[1:0])
                                       && first_cks_o == $past(reg_wdata_i[3:2]))
        else $error("first low duty or select from wrong bits");
    AST_FULL_RATE_TICK: assert property (
        second_cks_o == CKS_SYS [*3] |-> second_tick_o)
        else $error("full rate select missed a tick");
    AST_QUARTER_RATE: assert property (
        first_cks_o == CKS_DIV4 && first_tick_o && $stable(first_cks_o)
            |=> (!first_tick_o || $past(first_cks_o) != CKS_DIV4) [*3])
        else $error("quarter rate ticks too often");
    AST_PORT_TWO_PINS: assert property (
        s_wr(ADR_PORT_TWO_DATA) |=> port_two_pins_o == $past(reg_wdata_i[1:0]))
        else $error("port two pin data not written");
    AST_ADC_ROUTE: assert property (
        port_one_adc_o[5] == (port_one_mode_high_r[3:2] == MODE_3))
        else $error("pin 5 converter connect wrong");
    AST_PIN3_LOW_REG: assert property (
        s_wr(ADR_PORT_ONE_MODE_LOW) |=> port_one_mode_o[7:6] == $past(reg_wdata_i[7:6]))
        else $error("pin 3 mode field misplaced");
    AST_PORT_THREE_PIN3: assert property (
        s_wr(ADR_PORT_THREE_MODE_L) ##1 s_rd(ADR_PORT_THREE_MODE_L)
            |=> reg_rdata_o == {$past(reg_wdata_i[7:6], 2), 6'h00})
        else $error("port three pin 3 read back wrong");
    AST_READ_BACK: assert property (
        s_wr(ADR_SECOND_PERIOD) ##1 s_rd(ADR_SECOND_PERIOD) |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("second period read back differs");
    AST_THIRD_SELECT: assert property (
        s_wr(ADR_CONTROL_SECOND) |=> third_cks_o == $past(reg_wdata_i[3:2])
                                      && third_duty_o[1:0] == $past(reg_wdata_i[1:0]))
        else $error("third select or low duty wrong");
endmodule // pps_sfr_bank

// >>> tb.sv
`timescale 1ns/1ns
module tb;
    import pps_pkg::*;

    typedef struct packed {
        logic [7:0] a;    // register address
        logic [7:0] d;    // value written
        logic [7:0] rst;  // value read after reset
        logic [7:0] exp;  // value read after the write
    } pps_row_t;

    logic                 sys_clk_i       = 1'b0;
    logic                 resetn_i        = 1'b0;
    logic                 reg_wr_i        = 1'b0;
    logic                 reg_rd_i        = 1'b0;
    logic                 fast_rc_clock_i = 1'b0;
    logic [7:0]           reg_addr_i      = 8'h00;
    logic [7:0]           reg_wdata_i     = 8'h00;
    logic [7:0]           reg_rdata_o;
    logic [7:0]           first_period_o, second_period_o, third_period_o;
    logic [DUTY_W-1:0]    first_duty_o, second_duty_o, third_duty_o;
    logic [1:0]           first_cks_o, second_cks_o, third_cks_o, port_two_pins_o, port_three_pin3_mode_o;
    logic                 first_tick_o, second_tick_o, third_tick_o;
    logic [15:0]          port_one_mode_o;
    logic [ADC_PINS-1:0]  port_one_adc_o;
    int                   error_cnt  = 0;
    int                   num_checks = 0;
    logic [7:0]           rv;
    logic [3:0]           cyc = 4'h0;
    pps_row_t             rows [13];
    int                   n1, n2, n3;
    logic [15:0]          tick_exp [4];

    pps_sfr_bank dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .fast_rc_clock_i(fast_rc_clock_i), .first_period_o(first_period_o), .second_period_o(second_period_o),
        .third_period_o(third_period_o), .first_duty_o(first_duty_o), .second_duty_o(second_duty_o),
        .third_duty_o(third_duty_o), .first_cks_o(first_cks_o), .second_cks_o(second_cks_o),
        .third_cks_o(third_cks_o), .first_tick_o(first_tick_o), .second_tick_o(second_tick_o),
        .third_tick_o(third_tick_o), .port_two_pins_o(port_two_pins_o), .port_one_mode_o(port_one_mode_o),
        .port_one_adc_o(port_one_adc_o), .port_three_pin3_mode_o(port_three_pin3_mode_o));

    // system clock, 20 ns period
    always #10 sys_clk_i = ~sys_clk_i;

    // fast rc enable high three cycles out of four
    always @(posedge sys_clk_i) begin
        cyc             <= cyc + 4'h1;
        fast_rc_clock_i <= (cyc[1:0] != 2'h0);
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge sys_clk_i);
        reg_wr_i    <= 1'b0;
    endtask

    // read strobe one cycle, data sampled in the following cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge sys_clk_i);
        reg_rd_i   <= 1'b0;
        #1 d = reg_rdata_o;
    endtask

    // asynchronous reset entry, outputs checked while held
    task automatic do_reset();
        @(posedge sys_clk_i);
        resetn_i <= 1'b0;
        #1;
        chk({first_period_o, second_period_o}, 16'hffff);
        chk({8'h00, third_period_o}, 16'h00ff);
        chk({first_duty_o, second_duty_o[9:4]}, {10'h200, 6'h20});
        chk({second_duty_o, third_duty_o[9:4]}, {10'h200, 6'h20});
        chk({third_duty_o, first_cks_o, second_cks_o, third_cks_o}, {10'h200, 6'h2a});
        chk({port_two_pins_o, port_three_pin3_mode_o, port_one_adc_o}, {2'h3, 2'h1, 6'h00});
        chk(port_one_mode_o, 16'h5555);
        chk({first_tick_o, second_tick_o, third_tick_o, reg_rdata_o}, 16'h0000);
        repeat (8) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
    endtask

    // count enables of every channel over sixteen cycles
    task automatic count_ticks();
        n1 = 0; n2 = 0; n3 = 0;
        repeat (16) begin
            @(posedge sys_clk_i);
            #1;
            if (first_tick_o === 1'b1) n1++;
            if (second_tick_o === 1'b1) n2++;
            if (third_tick_o === 1'b1) n3++;
        end
    endtask

    initial begin
        #1000000;
        error_cnt++;
        report_and_stop();
    end

    initial begin
        rows = '{'{ADR_FIRST_PERIOD, 8'h12, 8'hff, 8'h12}, '{ADR_FIRST_DUTY_HIGH, 8'ha5, 8'h80, 8'ha5},
                 '{ADR_SECOND_PERIOD, 8'h00, 8'hff, 8'h00}, '{ADR_SECOND_DUTY_HIGH, 8'h3c, 8'h80, 8'h3c},
                 '{ADR_THIRD_PERIOD, 8'h7e, 8'hff, 8'h7e}, '{ADR_THIRD_DUTY_HIGH, 8'hc3, 8'h80, 8'hc3},
                 '{ADR_PORT_TWO_DATA, 8'h96, 8'hff, 8'h96}, '{ADR_CLOCK_DUTY_CTRL, 8'h6d, 8'h88, 8'h6d},
                 '{ADR_PORT_ONE_MODE_LOW, 8'he4, 8'h55, 8'he4}, '{ADR_PORT_ONE_MODE_HI, 8'h1b, 8'h55, 8'h1b},
                 '{ADR_PORT_THREE_MODE_L, 8'hff, 8'h40, 8'hc0}, '{ADR_CONTROL_SECOND, 8'hff, 8'h08, 8'h0f},
                 '{8'h50, 8'hff, 8'h00, 8'h00}};
        tick_exp = '{16'd4, 16'd8, 16'd16, 16'd12};
        do_reset();
        // reset value, write and read back of every register
        foreach (rows[i]) begin
            rd(rows[i].a, rv);
            chk(rv, rows[i].rst);
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rv);
            chk(rv, rows[i].exp);
        end
        // field placement on the outputs
        chk({6'h00, first_duty_o}, 16'h0295);
        chk({6'h00, second_duty_o}, 16'h00f2);
        chk({6'h00, third_duty_o}, 16'h030f);
        chk({first_period_o, second_period_o}, 16'h1200);
        chk({first_cks_o, second_cks_o, third_cks_o}, 16'h0037);
        chk(port_one_mode_o, 16'h1be4);
        chk({port_one_adc_o, port_three_pin3_mode_o, port_two_pins_o}, 16'h018e);
        // back-to-back write then read, data stands one cycle
        @(posedge sys_clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= ADR_SECOND_PERIOD;
        reg_wdata_i <= 8'h5a;
        @(posedge sys_clk_i);
        reg_wr_i    <= 1'b0;
        reg_rd_i    <= 1'b1;
        #1 chk({8'h00, second_period_o}, 16'h005a);
        @(posedge sys_clk_i);
        reg_rd_i    <= 1'b0;
        #1 chk({8'h00, reg_rdata_o}, 16'h005a);
        @(posedge sys_clk_i);
        #1 chk({8'h00, reg_rdata_o}, 16'h0000);
        // back-to-back write then read of the port three pin 3 field
        @(posedge sys_clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= ADR_PORT_THREE_MODE_L;
        reg_wdata_i <= 8'hbf;
        @(posedge sys_clk_i);
        reg_wr_i    <= 1'b0;
        reg_rd_i    <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i    <= 1'b0;
        #1 chk({8'h00, reg_rdata_o}, 16'h0080);
        // every clock select code on all three channels
        for (int c = 0; c < 4; c++) begin
            wr(ADR_CLOCK_DUTY_CTRL, {c[1:0], 2'h0, c[1:0], 2'h0});
            wr(ADR_CONTROL_SECOND, {4'h0, c[1:0], 2'h0});
            repeat (4) @(posedge sys_clk_i);
            count_ticks();
            chk({first_cks_o, second_cks_o, third_cks_o}, {10'h000, c[1:0], c[1:0], c[1:0]});
            chk(n1[15:0], tick_exp[c]);
            chk(n2[15:0], tick_exp[c]);
            chk(n3[15:0], tick_exp[c]);
        end
        // mode 3 on the two high pins leaves the converter alone
        wr(ADR_PORT_ONE_MODE_HI, 8'hf0);
        wr(ADR_PORT_ONE_MODE_LOW, 8'h00);
        #1 chk({10'h000, port_one_adc_o}, 16'h0000);
        wr(ADR_PORT_ONE_MODE_HI, 8'h0f);
        wr(ADR_PORT_ONE_MODE_LOW, 8'hff);
        #1 chk({10'h000, port_one_adc_o}, 16'h003f);
        // reset in mid-run brings back every reset value
        do_reset();
        rd(ADR_CLOCK_DUTY_CTRL, rv);
        chk(rv, 8'h88);
        report_and_stop();
    end
endmodule // tb
